// ===== transfer_coprocessor_control.v
// Control, status, program RAM and buffer arbitration of the transfer coprocessor
`include "coproc_map.vh"

// How it works
// - Init while running reloads pointer, deferred during internal interrupt routine.
// - Error and stop share one interrupt, gated by enables and global mask.
// - Control bit 4 enables the error interrupt; software only.
// - Control bit 3 enables the stop interrupt; software only.
// - Control bit 2 unlocks program RAM writes; settable only while stopped.
// - Writing 1 to init copies the pointer into the program counter.
// - Control bit 0 runs; settable only without load; cleared by stop flag.
// - Status bits 7 to 2 read as zero.
// - Error flag set on error while running; cleared by status read.
// - Stop flag set when execution ends; cleared by status read.
// - Write-only 8-bit pointer holds a function entry address.
// - All three registers reset to zero.
// - Shared buffer granted when free: core, then USB, then coprocessor.
module transfer_coprocessor_control #(
  parameter ADDR_W = 8,                       // Register address width
  parameter DEPTH  = `PROG_RAM_DEPTH          // Program RAM bytes
) (
  input  wire              clk_sys,           // System clock
  input  wire              rst_b,             // Async reset, active low
  input  wire [ADDR_W-1:0] reg_addr,          // Register address
  input  wire [7:0]        reg_wdata,         // Register write data
  input  wire              reg_wr,            // Register write strobe
  input  wire              reg_rd,            // Register read strobe
  output reg  [7:0]        reg_rdata,         // Read data, cycle after strobe
  input  wire [7:0]        ram_addr,          // Program RAM write address
  input  wire [7:0]        ram_wdata,         // Program RAM write data
  input  wire              ram_wr,            // Program RAM write strobe
  output reg               ram_wr_blocked,    // Pulse: RAM write refused
  input  wire [7:0]        fetch_addr,        // Engine fetch address
  output reg  [7:0]        fetch_data,        // Engine fetch data, next cycle
  input  wire              engine_stop,       // Engine ended at current instruction
  input  wire              engine_error,      // Engine error event
  input  wire              engine_isr_busy,   // Engine in internal interrupt routine
  output reg               engine_run,        // Engine enabled to execute
  output reg               engine_pc_load,    // Pulse: load new program counter
  output reg  [7:0]        entry_address,     // Program counter value to load
  input  wire              global_irq_mask,   // Core global interrupt mask, 1 = masked
  input  wire              core_halt,         // Core in HALT mode (async pin)
  output reg               coproc_irq,        // Shared interrupt request
  input  wire [2:0]        buf_req,           // Buffer requests: core, USB, coproc
  output reg  [2:0]        buf_grant          // Buffer grants
);

  // ==========================================================
  // Registers
  reg [4:0] control_q;
  reg [1:0] flags_q;
  reg [7:0] pointer_q;
  reg       init_pend_q;
  reg [7:0] ram [0:DEPTH-1];

  wire      halt_s;
  wire [2:0] grant_w;

  sync2 sync2_inst (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (core_halt),
    .q       (halt_s)
  );

  buffer_arbiter buffer_arbiter_inst (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .req     (buf_req),
    .grant   (grant_w),
    .owner   ()
  );

  wire wr_ctl = reg_wr && (reg_addr == `OFF_CONTROL);
  wire wr_ptr = reg_wr && (reg_addr == `OFF_ENTRY_POINTER);
  wire rd_flg = reg_rd && (reg_addr == `OFF_EVENT_FLAGS);

  wire run_now  = control_q[`CTL_RUN];
  wire load_now = control_q[`CTL_LOAD];

  // Effective run: halt freezes execution without touching the bit
  wire exec_on = run_now && !halt_s;

  wire set_stop  = exec_on && engine_stop;
  wire set_error = exec_on && engine_error;

  // ==========================================================
  // Control register
  reg [4:0] control_d;
  always @* begin
    control_d = control_q;
    if (wr_ctl) begin
      control_d[`CTL_ERR_EN]  = reg_wdata[`CTL_ERR_EN];
      control_d[`CTL_STOP_EN] = reg_wdata[`CTL_STOP_EN];
      control_d[`CTL_INIT]    = reg_wdata[`CTL_INIT];
      // Load may rise only while stopped
      if (!reg_wdata[`CTL_LOAD] || !run_now)
        control_d[`CTL_LOAD] = reg_wdata[`CTL_LOAD];
      // Run may rise only while load is clear
      if (!reg_wdata[`CTL_RUN] || !load_now)
        control_d[`CTL_RUN] = reg_wdata[`CTL_RUN];
    end
    if (set_stop || flags_q[`FLG_STOP])
      control_d[`CTL_RUN] = 1'b0;
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      control_q <= 5'h00;
    else
      control_q <= control_d;
  end

  // ==========================================================
  // Event flags, set beats read-clear
  reg [1:0] flags_d;
  always @* begin
    flags_d = flags_q;
    if (rd_flg)
      flags_d = 2'b00;
    if (set_stop)
      flags_d[`FLG_STOP] = 1'b1;
    if (set_error)
      flags_d[`FLG_ERROR] = 1'b1;
  end

  // ==========================================================
  // Pointer, init transfer and deferral
  wire init_wr = wr_ctl && reg_wdata[`CTL_INIT];
  wire init_go = (init_wr || init_pend_q) && !(run_now && engine_isr_busy);

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags_q        <= 2'b00;
      pointer_q      <= 8'h00;
      init_pend_q    <= 1'b0;
      engine_pc_load <= 1'b0;
      entry_address  <= 8'h00;
    end else begin
      flags_q <= flags_d;
      if (wr_ptr)
        pointer_q <= reg_wdata;
      engine_pc_load <= init_go;
      if (init_go) begin
        entry_address <= wr_ptr ? reg_wdata : pointer_q;
        init_pend_q   <= 1'b0;
      end else if (init_wr) begin
        init_pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Program RAM, write protected unless load is set
  always @(posedge clk_sys) begin
    if (ram_wr && load_now)
      ram[ram_addr] <= ram_wdata;
    fetch_data <= ram[fetch_addr];
  end

  // ==========================================================
  // Outputs and read data
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata      <= 8'h00;
      ram_wr_blocked <= 1'b0;
      engine_run     <= 1'b0;
      coproc_irq     <= 1'b0;
      buf_grant      <= 3'h0;
    end else begin
      ram_wr_blocked <= ram_wr && !load_now;
      engine_run     <= control_d[`CTL_RUN] && !halt_s;
      coproc_irq     <= !global_irq_mask &&
                        ((flags_d[`FLG_ERROR] && control_d[`CTL_ERR_EN]) ||
                         (flags_d[`FLG_STOP]  && control_d[`CTL_STOP_EN]));
      buf_grant      <= grant_w;
      reg_rdata      <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `OFF_CONTROL:     reg_rdata <= {3'h0, control_q};
          `OFF_EVENT_FLAGS: reg_rdata <= {6'h00, flags_q};
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ===== coproc_map.vh
// Register offsets, field positions and reset values of the transfer coprocessor control
`ifndef COPROC_MAP_VH
`define COPROC_MAP_VH

// ==========================================================
// Register offsets
`define OFF_CONTROL        8'h1c
`define OFF_EVENT_FLAGS    8'h1d
`define OFF_ENTRY_POINTER  8'h1f

// ==========================================================
// Control fields
`define CTL_RUN            0
`define CTL_INIT           1
`define CTL_LOAD           2
`define CTL_STOP_EN        3
`define CTL_ERR_EN         4
`define CTL_USED_MASK      8'h1f

// ==========================================================
// Event flag fields
`define FLG_STOP           0
`define FLG_ERROR          1

// ==========================================================
// Reset values
`define RST_CONTROL        8'h00
`define RST_EVENT_FLAGS    8'h00
`define RST_ENTRY_POINTER  8'h00

// ==========================================================
// Program RAM and buffer arbitration
`define PROG_RAM_DEPTH     256
`define ARB_CORE           2'h0
`define ARB_USB            2'h1
`define ARB_COPROC         2'h2
`define ARB_NONE           2'h3

`endif

// ===== sync2.v
// Two-stage synchroniser for a level from outside the clock domain
module sync2 (
  input  wire clk_sys, // System clock
  input  wire rst_b,   // Async reset, active low
  input  wire d,       // Asynchronous level
  output reg  q        // Synchronised level
);
  reg meta_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== buffer_arbiter.v
// Fixed-priority, non-preemptive arbiter for the shared data buffer
`include "coproc_map.vh"
module buffer_arbiter (
  input  wire       clk_sys,    // System clock
  input  wire       rst_b,      // Async reset, active low
  input  wire [2:0] req,        // Requests: 0 core, 1 USB, 2 coprocessor
  output reg  [2:0] grant,      // One-hot grant
  output reg  [1:0] owner       // Current owner code
);
  reg [2:0] grant_d;
  reg [1:0] owner_d;

  // Master keeps the buffer until it drops its request
  always @* begin
    grant_d = grant;
    owner_d = owner;
    if (grant == 3'h0 || (grant & req) == 3'h0) begin
      grant_d = 3'h0;
      owner_d = `ARB_NONE;
      if (req[0]) begin
        grant_d = 3'h1;
        owner_d = `ARB_CORE;
      end else if (req[1]) begin
        grant_d = 3'h2;
        owner_d = `ARB_USB;
      end else if (req[2]) begin
        grant_d = 3'h4;
        owner_d = `ARB_COPROC;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      grant <= 3'h0;
      owner <= `ARB_NONE;
    end else begin
      grant <= grant_d;
      owner <= owner_d;
    end
  end
endmodule

// ===== coproc_ctl_assertions.sv
// Concurrent checks on the transfer coprocessor control ports
module coproc_ctl_assertions #(
  parameter ADDR_W = 8                   // Register address width
) (
  input logic              clk_sys,          // Clock
  input logic              rst_b,            // Reset, low
  input logic [ADDR_W-1:0] reg_addr,         // Address
  input logic [7:0]        reg_wdata,        // Write data
  input logic              reg_wr,           // Write strobe
  input logic              reg_rd,           // Read strobe
  input logic [7:0]        reg_rdata,        // Read data
  input logic              ram_wr,           // RAM write
  input logic              ram_wr_blocked,   // RAM refusal
  input logic              engine_stop,      // Stop event
  input logic              engine_isr_busy,  // Routine busy
  input logic              engine_run,       // Run out
  input logic              engine_pc_load,   // Pointer load
  input logic              global_irq_mask,  // Mask
  input logic              core_halt,        // Halt
  input logic              coproc_irq,       // Interrupt
  input logic [2:0]        buf_req,          // Requests
  input logic [2:0]        buf_grant         // Grants
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Checks
  sequence s_init_wr;
    reg_wr && reg_addr == 8'h1c && reg_wdata[1] && !engine_isr_busy;
  endsequence
  sequence s_flag_rd;
    reg_rd && reg_addr == 8'h1d;
  endsequence
  chk_init_loads_pc: assert property (s_init_wr |=> engine_pc_load)
    else $error("init write gave no pointer load");
  chk_flags_upper_zero: assert property (s_flag_rd |=> reg_rdata[7:2] == 6'h00)
    else $error("flag read upper bits not zero");
  chk_pointer_unread: assert property (reg_rd && reg_addr == 8'h1f |=> reg_rdata == 8'h00)
    else $error("pointer read not zero");
  chk_irq_masked: assert property ($past(global_irq_mask) |-> !coproc_irq)
    else $error("interrupt while masked");
  chk_blocked_cause: assert property (ram_wr_blocked |-> $past(ram_wr))
    else $error("refusal without ram write");
  chk_stop_clears_run: assert property (engine_run && engine_stop |-> ##[1:2] !engine_run)
    else $error("run not cleared after stop");
  chk_halt_stops: assert property (core_halt [*5] |-> !engine_run)
    else $error("engine runs in halt");
  chk_grant_onehot: assert property ($onehot0(buf_grant))
    else $error("grant not one-hot");
  chk_core_first: assert property (buf_grant == 3'h0 && buf_req[0] && $past(buf_req) == 3'h0 |-> ##2 buf_grant == 3'h1)
    else $error("core not granted first");
endmodule

// ===== transfer_coprocessor_control_tb.sv
// Self-checking bench for the transfer coprocessor control
module transfer_coprocessor_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys, rst_b, reg_wr, reg_rd, ram_wr, engine_stop, engine_error, engine_isr_busy;
  logic       ram_wr_blocked, engine_run, engine_pc_load, global_irq_mask, core_halt, coproc_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ram_addr, ram_wdata, fetch_addr, fetch_data, entry_address;
  logic [2:0] buf_req, buf_grant;
  int         fail_count, comparisons;
  transfer_coprocessor_control transfer_coprocessor_control_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wr(ram_wr),
    .ram_wr_blocked(ram_wr_blocked), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .engine_stop(engine_stop), .engine_error(engine_error), .engine_isr_busy(engine_isr_busy),
    .engine_run(engine_run), .engine_pc_load(engine_pc_load), .entry_address(entry_address),
    .global_irq_mask(global_irq_mask), .core_halt(core_halt), .coproc_irq(coproc_irq),
    .buf_req(buf_req), .buf_grant(buf_grant));
  // ==========================================================
  // Bus and check tasks
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task ram(input logic [7:0] a, input logic [7:0] d, input logic blk, input logic [7:0] exp);
    @(posedge clk_sys);
    ram_wr <= 1'b1;
    ram_addr <= a;
    ram_wdata <= d;
    @(posedge clk_sys);
    ram_wr <= 1'b0;
    fetch_addr <= a;
    #1 chk("blocked", {7'h00, blk}, {7'h00, ram_wr_blocked});
    cyc(1);
    chk("fetch", exp, fetch_data);
  endtask
  task wait_pc;
    #1;
    for (int i = 0; i < 8; i++) begin
      if (engine_pc_load === 1'b1) return;
      cyc(1);
    end
    fail_count++;
    $display("[ERR] pc load expected 1 seen 0");
    tally_and_finish();
  endtask
  task pulse(input logic err);
    @(posedge clk_sys);
    if (err) engine_error <= 1'b1;
    else engine_stop <= 1'b1;
    @(posedge clk_sys);
    engine_error <= 1'b0;
    engine_stop <= 1'b0;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd(8'h1c, 8'h00, "control");
    rd(8'h1d, 8'h00, "flags");
    rd(8'h1f, 8'h00, "pointer");
    rd(8'h1e, 8'h00, "unmapped");
  endtask
  task t_load;
    wr(8'h1c, 8'h04);
    ram(8'h10, 8'h3c, 1'b0, 8'h3c);
    ram(8'h11, 8'h00, 1'b0, 8'h00);
    wr(8'h1c, 8'h05);
    rd(8'h1c, 8'h04, "run under load");
    wr(8'h1c, 8'h00);
    ram(8'h10, 8'hc3, 1'b1, 8'h3c);
    wr(8'h1c, 8'h01);
    rd(8'h1c, 8'h01, "control upper zero");
    wr(8'h1c, 8'h05);
    rd(8'h1c, 8'h01, "load while run");
    wr(8'h1c, 8'h00);
  endtask
  task t_init;
    wr(8'h1f, 8'h5a);
    wr(8'h1c, 8'h02);
    wait_pc();
    chk("entry", 8'h5a, entry_address);
    wr(8'h1c, 8'h00);
    wr(8'h1c, 8'h01);
    @(posedge clk_sys) engine_isr_busy <= 1'b1;
    wr(8'h1f, 8'h33);
    wr(8'h1c, 8'h03);
    cyc(3);
    chk("entry deferred", 8'h5a, entry_address);
    @(posedge clk_sys) engine_isr_busy <= 1'b0;
    wait_pc();
    chk("entry on fly", 8'h33, entry_address);
    wr(8'h1c, 8'h00);
  endtask
  task t_events;
    wr(8'h1c, 8'h19);
    pulse(1'b1);
    cyc(2);
    chk("irq error", 8'h01, {7'h00, coproc_irq});
    rd(8'h1d, 8'h02, "error flag");
    cyc(2);
    chk("irq cleared", 8'h00, {7'h00, coproc_irq});
    @(posedge clk_sys) global_irq_mask <= 1'b1;
    pulse(1'b0);
    cyc(2);
    chk("irq masked", 8'h00, {7'h00, coproc_irq});
    chk("run after stop", 8'h00, {7'h00, engine_run});
    rd(8'h1c, 8'h18, "control after stop");
    rd(8'h1d, 8'h01, "stop flag");
    rd(8'h1d, 8'h00, "flags read clear");
    @(posedge clk_sys) global_irq_mask <= 1'b0;
    wr(8'h1c, 8'h09);
    pulse(1'b0);
    cyc(2);
    chk("irq stop", 8'h01, {7'h00, coproc_irq});
    rd(8'h1d, 8'h01, "stop flag again");
    cyc(2);
    chk("irq stop cleared", 8'h00, {7'h00, coproc_irq});
  endtask
  task t_halt;
    wr(8'h1c, 8'h01);
    cyc(2);
    chk("run", 8'h01, {7'h00, engine_run});
    @(posedge clk_sys) core_halt <= 1'b1;
    cyc(6);
    chk("run halted", 8'h00, {7'h00, engine_run});
    @(posedge clk_sys) core_halt <= 1'b0;
    cyc(6);
    chk("run resumed", 8'h01, {7'h00, engine_run});
    wr(8'h1c, 8'h00);
  endtask
  task t_arb;
    @(posedge clk_sys) buf_req <= 3'h6;
    cyc(3);
    chk("grant usb", 8'h02, {5'h00, buf_grant});
    @(posedge clk_sys) buf_req <= 3'h7;
    cyc(3);
    chk("grant held", 8'h02, {5'h00, buf_grant});
    @(posedge clk_sys) buf_req <= 3'h5;
    cyc(3);
    chk("grant core", 8'h01, {5'h00, buf_grant});
    @(posedge clk_sys) buf_req <= 3'h0;
    cyc(3);
    chk("grant none", 8'h00, {5'h00, buf_grant});
    @(posedge clk_sys) buf_req <= 3'h1;
    cyc(3);
    chk("grant core free", 8'h01, {5'h00, buf_grant});
    @(posedge clk_sys) buf_req <= 3'h0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, ram_wr, engine_stop, engine_error, engine_isr_busy, global_irq_mask} = 8'h00;
    {reg_addr, reg_wdata, ram_addr, ram_wdata, fetch_addr} = 40'h0;
    {core_halt, buf_req} = 4'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_load();
    t_init();
    t_events();
    t_halt();
    t_arb();
    tally_and_finish();
  end
endmodule
bind transfer_coprocessor_control coproc_ctl_assertions #(.ADDR_W(ADDR_W)) coproc_ctl_assertions_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_wr(ram_wr), .ram_wr_blocked(ram_wr_blocked),
  .engine_stop(engine_stop), .engine_isr_busy(engine_isr_busy), .engine_run(engine_run),
  .engine_pc_load(engine_pc_load), .global_irq_mask(global_irq_mask), .core_halt(core_halt),
  .coproc_irq(coproc_irq), .buf_req(buf_req), .buf_grant(buf_grant));
